// ---- hdl/das_diagnostic_monitor.sv ----
`timescale 1ns/1ps
module das_diagnostic_monitor
    import diag_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                wd_clk,
    input  wire logic                software_mode,
    input  wire logic                reset_pulse,
    input  wire logic                regulator_cap_node_low,
    input  wire logic                ref_internal_sel,
    input  wire logic                status_header_en,
    input  wire logic                two_lines,
    input  wire reg_req_type         req,
    output logic [7:0]               rd_data,
    output logic [7:0]               rd_crc,
    output logic                     rd_valid,
    output logic                     full_reset_req,
    input  wire logic                conv_busy,
    input  wire logic [num_channels*16-1:0] conv_in,
    input  wire logic                conv_done,
    output logic [num_channels*16-1:0] conv_out,
    input  wire logic [1:0]          ser_bit_valid,
    input  wire logic [1:0]          ser_bit,
    input  wire logic                ser_frame_start,
    output logic [15:0]              ser_crc_a,
    output logic [15:0]              ser_crc_b,
    input  wire logic                par_word_valid,
    input  wire logic [15:0]         par_word,
    output logic [15:0]              par_crc,
    input  wire logic [2:0]          header_channel,
    input  wire logic [num_channels-1:0] ov_flags,
    input  wire logic [num_channels-1:0] uv_flags,
    output logic [7:0]               header,
    output logic [num_channels*3-1:0] node_sel,
    output logic [num_channels-1:0]  pin_connect,
    output logic                     ref_node_internal
);
    logic [7:0]  enables_r;
    logic [7:0]  flags_r;
    logic        reset_seen_r;
    logic [7:0]  sel_r [4];
    logic        busy_m, busy_s;
    logic        wd_rst_m, wd_rst;
    logic        stuck_tog;
    logic        tog_m, tog_s, tog_d;
    logic        wr_hit, rd_hit;
    logic        addr_valid, addr_writable;
    logic        crc_on;
    logic        reg_crc_bad;
    logic [7:0]  reg_crc_calc;
    logic [7:0]  rd_val;
    logic [15:0] par_shift_r;
    logic [3:0]  par_cnt_r;
    logic        par_busy_r;
    logic        rst_pulse_m, rst_pulse_s;
    logic        regulator_cap_node_m, regulator_cap_node_s;

    // reset and regulator pins are asynchronous: two flops before reset-seen use
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rst_pulse_m <= 1'b0;
            rst_pulse_s <= 1'b0;
            regulator_cap_node_m    <= 1'b0;
            regulator_cap_node_s    <= 1'b0;
        end
        else
        begin
            rst_pulse_m <= reset_pulse;
            rst_pulse_s <= rst_pulse_m;
            regulator_cap_node_m    <= regulator_cap_node_low;
            regulator_cap_node_s    <= regulator_cap_node_m;
        end
    end

    // regulator drop forces a full reset
    assign full_reset_req = regulator_cap_node_low;
    assign crc_on = software_mode && enables_r[bit_crc_en];
    assign wr_hit = req.valid && req.write && software_mode;
    assign rd_hit = req.valid && !req.write && software_mode;
    assign addr_valid = (req.addr <= addr_max_valid);
    assign addr_writable = addr_valid && (req.addr != addr_status);

    // software writes: enables, selectors
    always_ff @(posedge clk)
    begin
        if (srst)
            enables_r <= reg_reset_val;
        else if (wr_hit && !reg_crc_bad && req.addr == addr_enables)
            enables_r <= req.data;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_sel
            always_ff @(posedge clk)
            begin
                if (srst)
                    sel_r[g] <= reg_reset_val;
                else if (wr_hit && !reg_crc_bad && req.addr == addr_sel_first + 6'(g))
                    sel_r[g] <= req.data;
            end
        end
        for (g = 0; g < num_channels; g++)
        begin : g_node
            logic [2:0] code;
            assign code = sel_r[g/2][(g%2)*4 +: 3];
            // selection only meaningful in software mode
            assign node_sel[g*3 +: 3] = software_mode ? code : 3'b000;
            assign pin_connect[g] = (node_sel[g*3 +: 3] == 3'b000);
            // interface check replaces results
            always_ff @(posedge clk)
            begin
                if (srst)
                    conv_out[g*16 +: 16] <= '0;
                else if (conv_done)
                    conv_out[g*16 +: 16] <= (software_mode && enables_r[bit_link_test])
                        ? link_pattern[g] : conv_in[g*16 +: 16];
            end
        end
    endgenerate

    // reference node follows the source pin
    assign ref_node_internal = ref_internal_sel;

    // register-mode crc of the incoming address+data
    always_comb
    begin
        logic [15:0] d;
        logic [7:0]  c;
        d = {req.write ? 2'b00 : 2'b01, req.addr, req.data};
        c = '0;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? reg_crc_poly : 8'h00);
        reg_crc_calc = c;
    end
    assign reg_crc_bad = crc_on && req.crc_present && (req.crc != reg_crc_calc);

    // watchdog domain crossings
    always_ff @(posedge wd_clk)
    begin
        busy_m   <= conv_busy;
        busy_s   <= busy_m;
        wd_rst_m <= srst || !enables_r[bit_busy_chk];
        wd_rst   <= wd_rst_m;
    end

    busy_watchdog #(.limit(busy_limit_cycles)) u_wd (
        .wd_clk       (wd_clk),
        .wd_rst       (wd_rst),
        .busy_sync    (busy_s),
        .stuck_toggle (stuck_tog)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            tog_m <= 1'b0;
            tog_s <= 1'b0;
            tog_d <= 1'b0;
        end
        else
        begin
            tog_m <= stuck_tog;
            tog_s <= tog_m;
            tog_d <= tog_s;
        end
    end

    // error flags; hardware set wins over clear
    always_ff @(posedge clk)
    begin
        if (srst)
            flags_r <= reg_reset_val;
        else
        begin
            if (wr_hit && req.addr == addr_flags)
                flags_r <= flags_r & ~req.data;
            if (!enables_r[bit_rd_chk])
                flags_r[bit_rd_chk] <= 1'b0;
            if (!enables_r[bit_wr_chk])
                flags_r[bit_wr_chk] <= 1'b0;
            if (rd_hit && enables_r[bit_rd_chk] && !addr_valid)
                flags_r[bit_rd_chk] <= 1'b1;
            if (wr_hit && enables_r[bit_wr_chk] && !addr_writable)
                flags_r[bit_wr_chk] <= 1'b1;
            if (wr_hit && reg_crc_bad)
                flags_r[bit_crc_en] <= 1'b1;
            if (enables_r[bit_busy_chk] && (tog_s != tog_d))
                flags_r[bit_busy_chk] <= 1'b1;
        end
    end

    // reset-seen: any reset sets, status read clears
    always_ff @(posedge clk)
    begin
        if (srst)
            reset_seen_r <= 1'b1;
        else if (rst_pulse_s || regulator_cap_node_s)
            reset_seen_r <= 1'b1;
        else if (rd_hit && req.addr == addr_status)
            reset_seen_r <= 1'b0;
    end

    always_comb
    begin
        rd_val = 8'h00;
        if (req.addr == addr_status)
            rd_val = {reset_seen_r, |flags_r, 6'b0};
        else if (req.addr == addr_enables)
            rd_val = enables_r;
        else if (req.addr == addr_flags)
            rd_val = flags_r;
        else if (req.addr >= addr_sel_first && req.addr <= addr_sel_last)
            rd_val = sel_r[2'(req.addr - addr_sel_first)];
    end

    // read data with its 8-bit crc for bits 17 to 24
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_data  <= '0;
            rd_crc   <= '0;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_hit;
            if (rd_hit)
            begin
                rd_data <= rd_val;
                rd_crc  <= crc_on ? crc8(rd_val) : 8'h00;
            end
        end
    end

    function automatic logic [7:0] crc8(input logic [7:0] d);
        logic [7:0] c;
        c = '0;
        for (int i = 7; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? reg_crc_poly : 8'h00);
        return c;
    endfunction

    // serial line crcs; one line covers 128 bits, two cover 64
    crc_step #(.width(16), .poly(adc_crc_poly)) u_crc_a (
        .clk   (clk),
        .srst  (srst),
        .clear (ser_frame_start),
        .shift (crc_on && ser_bit_valid[0]),
        .din   (ser_bit[0]),
        .crc   (ser_crc_a)
    );
    crc_step #(.width(16), .poly(adc_crc_poly)) u_crc_b (
        .clk   (clk),
        .srst  (srst),
        .clear (ser_frame_start),
        .shift (crc_on && two_lines && ser_bit_valid[1]),
        .din   (ser_bit[1]),
        .crc   (ser_crc_b)
    );

    // parallel crc: each word is shifted in bitwise, msb first
    always_ff @(posedge clk)
    begin
        if (srst || ser_frame_start)
        begin
            par_shift_r <= '0;
            par_cnt_r   <= '0;
            par_busy_r  <= 1'b0;
        end
        else if (par_word_valid && crc_on)
        begin
            par_shift_r <= par_word;
            par_cnt_r   <= 4'hf;
            par_busy_r  <= 1'b1;
        end
        else if (par_busy_r)
        begin
            par_shift_r <= {par_shift_r[14:0], 1'b0};
            par_cnt_r   <= par_cnt_r - 4'd1;
            par_busy_r  <= (par_cnt_r != 4'h0);
        end
    end

    crc_step #(.width(16), .poly(adc_crc_poly)) u_crc_p (
        .clk   (clk),
        .srst  (srst),
        .clear (ser_frame_start),
        .shift (par_busy_r),
        .din   (par_shift_r[15]),
        .crc   (par_crc)
    );

    // status header: flags then channel number
    always_ff @(posedge clk)
    begin
        if (srst)
            header <= '0;
        else if (status_header_en && software_mode)
            header <= {reset_seen_r, |flags_r, 1'b0, ov_flags[header_channel],
                       uv_flags[header_channel], header_channel};
        else
            header <= '0;
    end
endmodule // das_diagnostic_monitor

// ---- hdl/diag_pkg.sv ----
package diag_pkg;
    localparam logic [5:0]  addr_status      = 6'h01;
    localparam logic [5:0]  addr_enables     = 6'h21;
    localparam logic [5:0]  addr_flags       = 6'h22;
    localparam logic [5:0]  addr_sel_first   = 6'h28;
    localparam logic [5:0]  addr_sel_last    = 6'h2b;
    localparam logic [5:0]  addr_max_valid   = 6'h2f;
    localparam int          bit_reset_seen   = 7;
    localparam int          bit_digital_err  = 6;
    localparam int          bit_link_test    = 7;
    localparam int          bit_busy_chk     = 5;
    localparam int          bit_rd_chk       = 4;
    localparam int          bit_wr_chk       = 3;
    localparam int          bit_crc_en       = 2;
    localparam logic [7:0]  reg_reset_val    = 8'h00;
    localparam logic [15:0] adc_crc_poly     = 16'h755b;
    localparam logic [7:0]  reg_crc_poly     = 8'h07;
    localparam int          num_channels     = 8;
    localparam real         busy_limit_ns    = 4000.0;
    localparam real         wd_clk_period_ns = 30.0;
    localparam int          busy_limit_cycles = int'(busy_limit_ns / wd_clk_period_ns);
    localparam logic [15:0] link_pattern [num_channels] = '{
        16'hacca, 16'h5cc5, 16'ha33a, 16'h5335,
        16'hcaac, 16'hc55c, 16'h3aa3, 16'h3553};

    typedef enum logic [7:0] {
        sel_external  = 8'h00,
        sel_temp      = 8'h01,
        sel_reference = 8'h02,
        sel_analog_reg = 8'h03,
        sel_digital_reg = 8'h04,
        sel_io_supply = 8'h05,
        sel_agnd      = 8'h06,
        sel_avcc      = 8'h07
    } node_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [5:0] addr;
        logic [7:0] data;
        logic       crc_present;
        logic [7:0] crc;
    } reg_req_type;
endpackage

// ---- hdl/crc_step.sv ----
`timescale 1ns/1ps
// serial crc engine, one data bit per clock, msb first
module crc_step
    import diag_pkg::*;
#(
    parameter int          width = 16,
    parameter logic [15:0] poly  = 16'h0000
)(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             clear,
    input  wire logic             shift,
    input  wire logic             din,
    output logic [width-1:0]      crc
);
    logic fb;
    assign fb = crc[width-1] ^ din;

    // equivalent to dividing data with appended zeros
    always_ff @(posedge clk)
    begin
        if (srst || clear)
            crc <= '0;
        else if (shift)
            crc <= {crc[width-2:0], 1'b0} ^ (fb ? poly[width-1:0] : '0);
    end
endmodule // crc_step

// ---- hdl/busy_watchdog.sv ----
`timescale 1ns/1ps
// times each internal conversion on the independent watchdog clock
module busy_watchdog
    import diag_pkg::*;
#(
    parameter int limit = busy_limit_cycles
)(
    input  wire logic wd_clk,
    input  wire logic wd_rst,
    input  wire logic busy_sync,
    output logic      stuck_toggle
);
    logic [15:0] count_r;
    logic        fired_r;

    always_ff @(posedge wd_clk)
    begin
        if (wd_rst)
        begin
            count_r      <= '0;
            fired_r      <= 1'b0;
            stuck_toggle <= 1'b0;
        end
        else if (!busy_sync)
        begin
            count_r <= '0;
            fired_r <= 1'b0;
        end
        else if (count_r < 16'(limit))
            count_r <= count_r + 16'd1;
        else if (!fired_r)
        begin
            fired_r      <= 1'b1;
            stuck_toggle <= ~stuck_toggle;
        end
    end
endmodule // busy_watchdog

// ---- testbench/diag_monitor_chk.sv ----
`timescale 1ns/1ps
module diag_monitor_chk
    import diag_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        software_mode,
    input wire reg_req_type req,
    input wire logic [7:0]  rd_data,
    input wire logic        rd_valid,
    input wire logic        reset_pulse,
    input wire logic        regulator_cap_node_low,
    input wire logic        full_reset_req,
    input wire logic        ref_internal_sel,
    input wire logic        ref_node_internal,
    input wire logic [23:0] node_sel,
    input wire logic [7:0]  pin_connect,
    input wire logic        status_header_en,
    input wire logic [2:0]  header_channel,
    input wire logic [7:0]  ov_flags,
    input wire logic [7:0]  header
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    logic rd_take;
    logic quiet;
    assign rd_take = req.valid && software_mode && !req.write;
    assign quiet = !reset_pulse && !regulator_cap_node_low;
    sequence stat_rd;
        rd_take && req.addr == addr_status && quiet;
    endsequence
    rd_answer_a: assert property (rd_take |=> rd_valid)
        else $error("read not answered");
    rd_quiet_a: assert property (!rd_take |=> !rd_valid)
        else $error("answer without read");
    stat_clear_a: assert property (stat_rd ##1 quiet ##1 stat_rd |=> !rd_data[7])
        else $error("reset seen not cleared by read");
    por_req_a: assert property (full_reset_req == regulator_cap_node_low)
        else $error("full reset request wrong");
    ref_node_a: assert property (ref_node_internal == ref_internal_sel)
        else $error("reference source wrong");
    pin_first_a: assert property (pin_connect[0] == (node_sel[2:0] == 3'b000))
        else $error("pin connect wrong");
    hdr_chan_a: assert property (status_header_en && software_mode |=>
        header[2:0] == $past(header_channel)) else $error("header channel wrong");
    hdr_over_a: assert property (status_header_en && software_mode |=>
        header[4] == $past(ov_flags[header_channel])) else $error("header flag wrong");
    cover property (stat_rd);
    cover property (req.valid && req.write);
    cover property (status_header_en && header[4]);
endmodule // diag_monitor_chk

bind das_diagnostic_monitor diag_monitor_chk chk (
    .clk(clk), .srst(srst), .software_mode(software_mode), .req(req),
    .rd_data(rd_data), .rd_valid(rd_valid), .reset_pulse(reset_pulse),
    .regulator_cap_node_low(regulator_cap_node_low), .full_reset_req(full_reset_req),
    .ref_internal_sel(ref_internal_sel), .ref_node_internal(ref_node_internal),
    .node_sel(node_sel), .pin_connect(pin_connect), .ov_flags(ov_flags),
    .status_header_en(status_header_en), .header_channel(header_channel), .header(header)
);

// ---- testbench/host_model.sv ----
`timescale 1ns/1ps
module host_model
    import diag_pkg::*;
(
    input wire logic       clk,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] rd_crc,
    output reg_req_type    req
);
    initial req = '0;
    // msb-first long division of n bits, w-bit remainder
    function automatic logic [15:0] crc(logic [127:0] d, int n, int w, logic [15:0] p);
        logic [15:0] c;
        logic fb;
        c = 16'h0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            fb = c[w-1] ^ d[i];
            c = {c[14:0], 1'b0};
            if (fb)
                c = c ^ p;
        end
        if (w == 8)
            c[15:8] = 8'h00;
        return c;
    endfunction
    // bad flips the crc lsb to provoke a mismatch
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                        input logic bad, output logic [7:0] q, output logic [7:0] qc);
        logic [15:0] c;
        c = crc({112'h0, 1'b0, !w, a, d}, 16, 8, {8'h00, reg_crc_poly});
        @(negedge clk);
        req = '{1'b1, w, a, d, 1'b1, c[7:0] ^ {7'h00, bad}};
        @(negedge clk);
        req.valid = 1'b0;
        q = rd_data;
        qc = rd_crc;
    endtask
endmodule // host_model

// ---- testbench/das_diagnostic_monitor_test.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED at %0t: got %h exp %h", $time, (a), (e)); end end
module das_diagnostic_monitor_test
    import diag_pkg::*;
;
    logic clk, srst, wd_clk, software_mode, reset_pulse, regulator_cap_node_low, crc_on;
    logic ref_internal_sel, status_header_en, two_lines, rd_valid, full_reset_req;
    logic conv_busy, conv_done, par_word_valid, ser_frame_start, ref_node_internal;
    logic [7:0] rd_data, rd_crc, header, ov_flags, uv_flags, pin_connect, q, qc;
    logic [1:0] ser_bit_valid, ser_bit;
    logic [15:0] ser_crc_a, ser_crc_b, par_word, par_crc;
    logic [2:0] header_channel;
    logic [23:0] node_sel;
    logic [127:0] conv_in, conv_out, d;
    reg_req_type req;
    int miscompares, comparisons;

    das_diagnostic_monitor uut (.clk(clk), .srst(srst), .wd_clk(wd_clk),
        .software_mode(software_mode), .reset_pulse(reset_pulse), .regulator_cap_node_low(regulator_cap_node_low),
        .ref_internal_sel(ref_internal_sel), .status_header_en(status_header_en),
        .two_lines(two_lines), .req(req), .rd_data(rd_data), .rd_crc(rd_crc),
        .rd_valid(rd_valid), .full_reset_req(full_reset_req), .conv_busy(conv_busy),
        .conv_in(conv_in), .conv_done(conv_done), .conv_out(conv_out),
        .ser_bit_valid(ser_bit_valid), .ser_bit(ser_bit), .ser_frame_start(ser_frame_start),
        .ser_crc_a(ser_crc_a), .ser_crc_b(ser_crc_b), .par_word_valid(par_word_valid),
        .par_word(par_word), .par_crc(par_crc), .header_channel(header_channel),
        .ov_flags(ov_flags), .uv_flags(uv_flags), .header(header), .node_sel(node_sel),
        .pin_connect(pin_connect), .ref_node_internal(ref_node_internal));
    host_model host (.clk(clk), .rd_data(rd_data), .rd_crc(rd_crc), .req(req));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        wd_clk = 1'b0;
        #7;
        forever #15 wd_clk = ~wd_clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        miscompares++;
        conclude();
    end

    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        host.xfer(1'b1, a, v, 1'b0, q, qc);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        host.xfer(1'b0, a, 8'h00, 1'b0, q, qc);
        `CHK(q, e)
        if (crc_on)
            `CHK({8'h00, qc}, host.crc({120'h0, e}, 8, 8, {8'h00, reg_crc_poly}))
    endtask
    task automatic busy(input int n);
        conv_busy = 1'b1;
        repeat (n) @(negedge clk);
        conv_busy = 1'b0;
        repeat (25) @(negedge clk);
    endtask
    task automatic frame;
        ser_frame_start = 1'b1;
        @(negedge clk);
        ser_frame_start = 1'b0;
    endtask
    task automatic ser(input int n);
        frame();
        for (int i = 0; i < n; i++)
        begin
            ser_bit_valid = {two_lines, 1'b1};
            ser_bit = {two_lines & d[63 - i], d[127 - i]};
            @(negedge clk);
        end
        ser_bit_valid = 2'b00;
        repeat (3) @(negedge clk);
    endtask

    initial
    begin
        {reset_pulse, regulator_cap_node_low, ref_internal_sel, status_header_en, two_lines} = '0;
        {conv_busy, conv_done, par_word_valid, ser_frame_start, crc_on} = '0;
        {ov_flags, uv_flags, ser_bit_valid, ser_bit, header_channel, par_word} = '0;
        conv_in = '0;
        d = '0;
        srst = 1'b1;
        software_mode = 1'b1;
        repeat (3) @(posedge wd_clk);
        @(negedge clk);
        srst = 1'b0;
        wr(addr_status, 8'h00);
        rchk(addr_status, 8'h80);
        rchk(addr_status, 8'h00);
        software_mode = 1'b0;
        wr(addr_enables, 8'h04);
        software_mode = 1'b1;
        rchk(addr_enables, 8'h00);
        host.xfer(1'b1, addr_enables, 8'h3c, 1'b1, q, qc);
        crc_on = 1'b1;
        rchk(addr_enables, 8'h3c);
        host.xfer(1'b1, addr_sel_first, 8'h55, 1'b1, q, qc);
        rchk(addr_sel_first, 8'h00);
        host.xfer(1'b0, 6'h30, 8'h00, 1'b0, q, qc);
        wr(addr_status, 8'h00);
        rchk(addr_flags, 8'h1c);
        wr(addr_flags, 8'h0c);
        rchk(addr_flags, 8'h10);
        wr(addr_enables, 8'h2c);
        rchk(addr_flags, 8'h00);
        busy(750);
        busy(750);
        rchk(addr_flags, 8'h00);
        busy(1100);
        rchk(addr_flags, 8'h20);
        wr(addr_flags, 8'h20);
        rchk(addr_flags, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr(addr_sel_first, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
            `CHK(node_sel[5:0], {3'(7 - c), 3'(c)})
            `CHK(pin_connect[1:0], {c == 7, c == 0})
        end
        wr(addr_sel_last, 8'h65);
        `CHK({node_sel[23:18], pin_connect[7:6]}, 8'hd4)
        for (int r = 0; r < 2; r++)
        begin
            ref_internal_sel = r[0];
            #1;
            `CHK(ref_node_internal, r[0])
        end
        wr(addr_enables, 8'h84);
        conv_in = {8{16'h1234}};
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
        @(negedge clk);
        for (int i = 0; i < 8; i++)
        begin
            `CHK(conv_out[16*i +: 16], link_pattern[i])
            d = {d[111:0], link_pattern[i]};
        end
        frame();
        for (int i = 0; i < 8; i++)
        begin
            par_word = d[127 - 16*i -: 16];
            par_word_valid = 1'b1;
            @(negedge clk);
            par_word_valid = 1'b0;
            repeat (17) @(negedge clk);
        end
        `CHK(par_crc, host.crc(d, 128, 16, adc_crc_poly))
        ser(128);
        `CHK(ser_crc_a, host.crc(d, 128, 16, adc_crc_poly))
        two_lines = 1'b1;
        ser(64);
        `CHK(ser_crc_a, host.crc(d >> 64, 64, 16, adc_crc_poly))
        `CHK(ser_crc_b, host.crc(d, 64, 16, adc_crc_poly))
        status_header_en = 1'b1;
        header_channel = 3'd3;
        ov_flags = 8'h08;
        repeat (2) @(negedge clk);
        `CHK(header[4:0], 5'b10011)
        {ov_flags, uv_flags} = {8'h00, 8'h08};
        repeat (2) @(negedge clk);
        `CHK(header[4:0], 5'b01011)
        wr(addr_enables, 8'h00);
        crc_on = 1'b0;
        reset_pulse = 1'b1;
        @(negedge clk);
        reset_pulse = 1'b0;
        repeat (3) @(negedge clk);
        rchk(addr_status, 8'h80);
        rchk(addr_status, 8'h00);
        regulator_cap_node_low = 1'b1;
        @(negedge clk);
        `CHK(full_reset_req, 1'b1)
        regulator_cap_node_low = 1'b0;
        repeat (3) @(negedge clk);
        rchk(addr_status, 8'h80);
        conclude();
    end
endmodule // das_diagnostic_monitor_test
